/* design/adfs_pkg.sv */
/*
 * Constants for the amplifier diagnostic and fault status bank: register
 * offsets, field positions, reset values and state codes.
 * Assumes an eight-bit register address and eight-bit register data.
 */
package adfs_pkg;

	// ***********************************************************
	// Register offsets
	// ***********************************************************
	localparam logic [7:0] ADFS_OFS_DC_DIAG = 8'h0c;
	localparam logic [7:0] ADFS_OFS_LINE_OUT = 8'h0e;
	localparam logic [7:0] ADFS_OFS_STATE = 8'h0f;
	localparam logic [7:0] ADFS_OFS_CH_FAULT = 8'h10;
	localparam logic [7:0] ADFS_OFS_GLOBAL1 = 8'h11;
	localparam logic [7:0] ADFS_OFS_GLOBAL2 = 8'h12;
	localparam logic [7:0] ADFS_OFS_WARN = 8'h13;
	localparam logic [7:0] ADFS_OFS_PIN_MASK = 8'h14;

	// ***********************************************************
	// Reset values
	// ***********************************************************
	localparam logic [7:0] ADFS_RST_DC_DIAG = 8'h00;
	localparam logic [7:0] ADFS_RST_LINE_OUT = 8'h00;
	localparam logic [7:0] ADFS_RST_STATE = 8'h55;
	localparam logic [7:0] ADFS_RST_CH_FAULT = 8'h00;
	localparam logic [7:0] ADFS_RST_GLOBAL1 = 8'h00;
	localparam logic [7:0] ADFS_RST_GLOBAL2 = 8'h00;
	localparam logic [7:0] ADFS_RST_WARN = 8'h20;
	localparam logic [7:0] ADFS_RST_PIN_MASK = 8'h00;
	localparam logic [7:0] ADFS_UNMAPPED_DATA = 8'h00;

	// ***********************************************************
	// Channel state codes
	// ***********************************************************
	localparam logic [1:0] ADFS_ST_PLAY = 2'h0;
	localparam logic [1:0] ADFS_ST_HIGH_IMPEDANCE_STATE = 2'h1;
	localparam logic [1:0] ADFS_ST_MUTE = 2'h2;
	localparam logic [1:0] ADFS_ST_DC_DIAG = 2'h3;
	localparam logic [1:0] ADFS_ST_RSVD_FIELD = 2'h1;

	// ***********************************************************
	// Field positions
	// ***********************************************************
	localparam int ADFS_BIT_LO_CH_ONE = 3;
	localparam int ADFS_BIT_LO_CH_TWO = 2;
	localparam int ADFS_BIT_OC_CH_ONE = 7;
	localparam int ADFS_BIT_OC_CH_TWO = 6;
	localparam int ADFS_BIT_DC_CH_ONE = 3;
	localparam int ADFS_BIT_DC_CH_TWO = 2;
	localparam int ADFS_BIT_INVALID_CLOCK = 4;
	localparam int ADFS_BIT_STAGE_OVER = 3;
	localparam int ADFS_BIT_BATTERY_OVER = 2;
	localparam int ADFS_BIT_STAGE_UNDER = 1;
	localparam int ADFS_BIT_BATTERY_UNDER = 0;
	localparam int ADFS_BIT_THERMAL_GLOBAL = 4;
	localparam int ADFS_BIT_THERMAL_CH_ONE = 3;
	localparam int ADFS_BIT_THERMAL_CH_TWO = 2;
	localparam int ADFS_BIT_CORE_POR = 5;
	localparam int ADFS_BIT_WARM_GLOBAL = 4;
	localparam int ADFS_BIT_WARM_CH_ONE = 3;
	localparam int ADFS_BIT_WARM_CH_TWO = 2;
	// Pin mask register fields
	localparam int ADFS_BIT_MASK_OC = 7;
	localparam int ADFS_BIT_MASK_THERMAL = 6;
	localparam int ADFS_BIT_MASK_UNDER = 5;
	localparam int ADFS_BIT_MASK_OVER = 4;
	localparam int ADFS_BIT_MASK_DC = 3;
	localparam int ADFS_BIT_MASK_ILIMIT = 2;
	localparam int ADFS_BIT_MASK_CLIP = 1;
	localparam int ADFS_BIT_MASK_WARM = 0;

	// True for every offset that answers a read with register data
	function automatic logic adfs_is_mapped(input logic [7:0] addr);
		adfs_is_mapped = (addr == ADFS_OFS_DC_DIAG) || (addr == ADFS_OFS_LINE_OUT) ||
			((addr >= ADFS_OFS_STATE) && (addr <= ADFS_OFS_PIN_MASK));
	endfunction : adfs_is_mapped

endpackage : adfs_pkg

/* design/adfs_pin_drive.sv */
/*
 * Open-drain fault and warning pin drivers with per-category masking.
 * Assumes synchronous fault levels, registered except ilimit_in, clip_in and warm_in, and the pin mask byte.
 */
`timescale 1ns/1ps

module adfs_pin_drive (
	input wire logic clk_in, // System clock
	input wire logic reset_in, // Synchronous reset, high
	input wire logic [7:0] mask_in, // Pin mask byte
	input wire logic oc_in, // Any overcurrent
	input wire logic thermal_in, // Any thermal shutdown
	input wire logic under_in, // Any undervoltage
	input wire logic over_in, // Any overvoltage
	input wire logic dc_in, // Any DC fault
	input wire logic ilimit_in, // Current limit active
	input wire logic clip_in, // Clipping
	input wire logic warm_in, // Any overtemperature warning
	output logic fault_pin_oe_out, // Fault pin pulled low
	output logic warn_pin_oe_out // Warn pin pulled low
);
	import adfs_pkg::*;

	typedef struct packed {
		logic fault;
		logic warn;
	} adfs_pin_t;

	adfs_pin_t st_q;
	adfs_pin_t st_d;

	// ***********************************************************
	// Masked category merge
	// ***********************************************************
	// masked fault report
	always_comb begin
		st_d.fault = (oc_in && !mask_in[ADFS_BIT_MASK_OC]) ||
			(thermal_in && !mask_in[ADFS_BIT_MASK_THERMAL]) ||
			(under_in && !mask_in[ADFS_BIT_MASK_UNDER]) ||
			(over_in && !mask_in[ADFS_BIT_MASK_OVER]) ||
			(dc_in && !mask_in[ADFS_BIT_MASK_DC]) ||
			(ilimit_in && !mask_in[ADFS_BIT_MASK_ILIMIT]);
		st_d.warn = (clip_in && !mask_in[ADFS_BIT_MASK_CLIP]) ||
			(warm_in && !mask_in[ADFS_BIT_MASK_WARM]);
	end

	// Registered so the pins never glitch on mask writes
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign fault_pin_oe_out = st_q.fault;
	assign warn_pin_oe_out = st_q.warn;

endmodule : adfs_pin_drive

/* design/adfs_status_bank.sv */
/*
 * Diagnostic and fault status register bank of a two-channel amplifier,
 * with the pin mask register and the open-drain fault and warning pins.
 * Assumes the serial control interface delivers byte reads and writes
 * on the register port, and all fault inputs are synchronous to clk_in.
 */
`timescale 1ns/1ps

// Behaviour
// - Result byte bits 7..4 hold channel one ground, power, open, shorted flags.
// - Result byte bits 3..0 hold the same four flags for channel two.
// - Line output found: channel one bit 3, channel two bit 2, reset zero.
// - State report resets to 0x55; codes play, high impedance, mute, diagnostics.
// - Channel one state in bits 7..6, two in 5..4, lower fields read 01.
// - Fault byte bit 7 and 6 show channel one and two overcurrent.
// - Fault byte bit 3 and 2 show DC faults, other bits zero.
// - Global byte one bit 4 flags invalid clock, bits 7..5 read zero.
// - Bits 3..0 show stage over, battery over, stage under, battery under.
// - Global byte two bits 4,3,2 show global, channel one, two thermal shutdown.
// - Warning byte resets to 0x20, bit 5 marks core power-on reset.
// - Unmasked fault categories drive the fault pin; mask bits suppress them.
module adfs_status_bank (
	input wire logic clk_in, // System clock, 100 MHz
	input wire logic reset_in, // Synchronous reset, high
	input wire logic [7:0] reg_addr_in, // Register offset
	input wire logic reg_wr_in, // Write strobe
	input wire logic [7:0] reg_wdata_in, // Write data
	input wire logic reg_rd_in, // Read strobe
	output logic [7:0] reg_rdata_out, // Read data
	output logic reg_rvalid_out, // Read data valid pulse
	input wire logic ch_one_short_ground_in, // Diagnostic result
	input wire logic ch_one_short_power_in, // Diagnostic result
	input wire logic ch_one_open_load_in, // Diagnostic result
	input wire logic ch_one_shorted_load_in, // Diagnostic result
	input wire logic ch_two_short_ground_in, // Diagnostic result
	input wire logic ch_two_short_power_in, // Diagnostic result
	input wire logic ch_two_open_load_in, // Diagnostic result
	input wire logic ch_two_shorted_load_in, // Diagnostic result
	input wire logic ch_one_line_out_found_in, // Line output found
	input wire logic ch_two_line_out_found_in, // Line output found
	input wire logic [1:0] ch_one_state_code_in, // Channel one state
	input wire logic [1:0] ch_two_state_code_in, // Channel two state
	input wire logic ch_one_overcurrent_in, // Overcurrent
	input wire logic ch_two_overcurrent_in, // Overcurrent
	input wire logic ch_one_dc_fault_in, // DC fault
	input wire logic ch_two_dc_fault_in, // DC fault
	input wire logic invalid_clock_in, // Input clock fault
	input wire logic stage_supply_over_in, // Supply fault
	input wire logic battery_over_in, // Supply fault
	input wire logic stage_supply_under_in, // Supply fault
	input wire logic battery_under_in, // Supply fault
	input wire logic global_thermal_off_in, // Thermal shutdown
	input wire logic ch_one_thermal_off_in, // Thermal shutdown
	input wire logic ch_two_thermal_off_in, // Thermal shutdown
	input wire logic global_thermal_warn_in, // Thermal warning
	input wire logic ch_one_thermal_warn_in, // Thermal warning
	input wire logic ch_two_thermal_warn_in, // Thermal warning
	input wire logic clip_in, // Output clipping
	input wire logic ilimit_in, // Current limit active
	input wire logic fault_pin_in, // Fault wire level, unused
	output logic fault_pin_out, // Fault pin drive level
	output logic fault_pin_oe_out, // Fault pin enable
	input wire logic warn_pin_in, // Warn wire level, unused
	output logic warn_pin_out, // Warn pin drive level
	output logic warn_pin_oe_out // Warn pin enable
);
	import adfs_pkg::*;

	// ***********************************************************
	// State
	// ***********************************************************
	typedef struct packed {
		logic [7:0] dc_diag;
		logic [7:0] line_out;
		logic [7:0] state_rep;
		logic [7:0] ch_fault;
		logic [7:0] global1;
		logic [7:0] global2;
		logic [7:0] warn;
		logic [7:0] pin_mask;
		logic [7:0] rdata;
		logic rvalid;
	} adfs_bank_t;

	adfs_bank_t st_q;
	adfs_bank_t st_d;

	// ***********************************************************
	// Flag capture and register port
	// ***********************************************************
	// Status bytes follow their sources every cycle; only the power-on bit of the
	// warning byte is sticky, so other bits read the live condition one cycle late.
	always_comb begin
		st_d = st_q;

		st_d.dc_diag[7] = ch_one_short_ground_in;
		st_d.dc_diag[6] = ch_one_short_power_in;
		st_d.dc_diag[5] = ch_one_open_load_in;
		st_d.dc_diag[4] = ch_one_shorted_load_in;
		st_d.dc_diag[3] = ch_two_short_ground_in;
		st_d.dc_diag[2] = ch_two_short_power_in;
		st_d.dc_diag[1] = ch_two_open_load_in;
		st_d.dc_diag[0] = ch_two_shorted_load_in;

		st_d.line_out = 8'h00;
		st_d.line_out[ADFS_BIT_LO_CH_ONE] = ch_one_line_out_found_in;
		st_d.line_out[ADFS_BIT_LO_CH_TWO] = ch_two_line_out_found_in;

		st_d.state_rep = {ch_one_state_code_in, ch_two_state_code_in,
			ADFS_ST_RSVD_FIELD, ADFS_ST_RSVD_FIELD};

		st_d.ch_fault = 8'h00;
		st_d.ch_fault[ADFS_BIT_OC_CH_ONE] = ch_one_overcurrent_in;
		st_d.ch_fault[ADFS_BIT_OC_CH_TWO] = ch_two_overcurrent_in;
		st_d.ch_fault[ADFS_BIT_DC_CH_ONE] = ch_one_dc_fault_in;
		st_d.ch_fault[ADFS_BIT_DC_CH_TWO] = ch_two_dc_fault_in;

		st_d.global1 = 8'h00;
		st_d.global1[ADFS_BIT_INVALID_CLOCK] = invalid_clock_in;
		st_d.global1[ADFS_BIT_STAGE_OVER] = stage_supply_over_in;
		st_d.global1[ADFS_BIT_BATTERY_OVER] = battery_over_in;
		st_d.global1[ADFS_BIT_STAGE_UNDER] = stage_supply_under_in;
		st_d.global1[ADFS_BIT_BATTERY_UNDER] = battery_under_in;

		st_d.global2 = 8'h00;
		st_d.global2[ADFS_BIT_THERMAL_GLOBAL] = global_thermal_off_in;
		st_d.global2[ADFS_BIT_THERMAL_CH_ONE] = ch_one_thermal_off_in;
		st_d.global2[ADFS_BIT_THERMAL_CH_TWO] = ch_two_thermal_off_in;

		// power-on flag holds from reset; reserved bits stay zero
		st_d.warn = 8'h00;
		st_d.warn[ADFS_BIT_CORE_POR] = st_q.warn[ADFS_BIT_CORE_POR];
		st_d.warn[ADFS_BIT_WARM_GLOBAL] = global_thermal_warn_in;
		st_d.warn[ADFS_BIT_WARM_CH_ONE] = ch_one_thermal_warn_in;
		st_d.warn[ADFS_BIT_WARM_CH_TWO] = ch_two_thermal_warn_in;

		// only the mask register takes writes
		if (reg_wr_in && (reg_addr_in == ADFS_OFS_PIN_MASK)) begin
			st_d.pin_mask = reg_wdata_in;
		end

		st_d.rvalid = reg_rd_in;
		if (reg_rd_in) begin
			if (!adfs_is_mapped(reg_addr_in)) begin
				st_d.rdata = ADFS_UNMAPPED_DATA;
			end else begin
				case (reg_addr_in)
					ADFS_OFS_DC_DIAG: st_d.rdata = st_q.dc_diag;
					ADFS_OFS_LINE_OUT: st_d.rdata = st_q.line_out;
					ADFS_OFS_STATE: st_d.rdata = st_q.state_rep;
					ADFS_OFS_CH_FAULT: st_d.rdata = st_q.ch_fault;
					ADFS_OFS_GLOBAL1: st_d.rdata = st_q.global1;
					ADFS_OFS_GLOBAL2: st_d.rdata = st_q.global2;
					ADFS_OFS_WARN: st_d.rdata = st_q.warn;
					ADFS_OFS_PIN_MASK: st_d.rdata = st_q.pin_mask;
					default: st_d.rdata = ADFS_UNMAPPED_DATA;
				endcase
			end
		end
	end

	// reset values, state byte at 0x55
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_q.dc_diag <= ADFS_RST_DC_DIAG;
			st_q.line_out <= ADFS_RST_LINE_OUT;
			st_q.state_rep <= ADFS_RST_STATE;
			st_q.ch_fault <= ADFS_RST_CH_FAULT;
			st_q.global1 <= ADFS_RST_GLOBAL1;
			st_q.global2 <= ADFS_RST_GLOBAL2;
			st_q.warn <= ADFS_RST_WARN;
			st_q.pin_mask <= ADFS_RST_PIN_MASK;
			st_q.rdata <= ADFS_UNMAPPED_DATA;
			st_q.rvalid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata_out = st_q.rdata;
	assign reg_rvalid_out = st_q.rvalid;

	// ***********************************************************
	// Fault and warning pins
	// ***********************************************************
	// Open drain: the level is always low, only the enable moves
	assign fault_pin_out = 1'b0;
	assign warn_pin_out = 1'b0;

	adfs_pin_drive u_pins (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.mask_in(st_q.pin_mask),
		.oc_in(st_q.ch_fault[ADFS_BIT_OC_CH_ONE] || st_q.ch_fault[ADFS_BIT_OC_CH_TWO]),
		.thermal_in(|st_q.global2),
		.under_in(st_q.global1[ADFS_BIT_STAGE_UNDER] || st_q.global1[ADFS_BIT_BATTERY_UNDER]),
		.over_in(st_q.global1[ADFS_BIT_STAGE_OVER] || st_q.global1[ADFS_BIT_BATTERY_OVER]),
		.dc_in(st_q.ch_fault[ADFS_BIT_DC_CH_ONE] || st_q.ch_fault[ADFS_BIT_DC_CH_TWO]),
		.ilimit_in(ilimit_in),
		.clip_in(clip_in),
		.warm_in(global_thermal_warn_in || ch_one_thermal_warn_in || ch_two_thermal_warn_in),
		.fault_pin_oe_out(fault_pin_oe_out),
		.warn_pin_oe_out(warn_pin_oe_out)
	);

endmodule : adfs_status_bank

/* bench/adfs_status_bank_chk.sv */
/* Checker of the status bank read port.
   Assumes a bind to adfs_status_bank and reads strobed one cycle each. */
`timescale 1ns/1ps

module adfs_status_bank_chk (
	input wire logic clk_in, // Clock
	input wire logic reset_in, // Sync reset
	input wire logic [7:0] reg_addr_in, // Offset
	input wire logic reg_rd_in, // Read strobe
	input wire logic [7:0] reg_rdata_out, // Read data
	input wire logic reg_rvalid_out, // Read valid
	input wire logic ch_one_short_ground_in, // Flag
	input wire logic ch_two_shorted_load_in, // Flag
	input wire logic ch_one_line_out_found_in, // Flag
	input wire logic ch_one_overcurrent_in, // Flag
	input wire logic global_thermal_off_in // Flag
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ****************
	// Read answers
	// ****************
	// Data seen two edges back, since flags are registered first
	property p_dc;
		reg_rvalid_out && $past(reg_addr_in) == 8'h0c |->
			reg_rdata_out[7] == $past(ch_one_short_ground_in, 2) &&
			reg_rdata_out[0] == $past(ch_two_shorted_load_in, 2);
	endproperty
	a_dc: assert property (p_dc) else $error("diag byte wrong");
	property p_lo;
		reg_rvalid_out && $past(reg_addr_in) == 8'h0e |-> reg_rdata_out[7:4] == 4'h0 &&
			reg_rdata_out[3] == $past(ch_one_line_out_found_in, 2);
	endproperty
	a_lo: assert property (p_lo) else $error("line out byte wrong");
	property p_st;
		reg_rvalid_out && $past(reg_addr_in) == 8'h0f |-> reg_rdata_out[3:0] == 4'h5;
	endproperty
	a_st: assert property (p_st) else $error("state low fields wrong");
	property p_cf;
		reg_rvalid_out && $past(reg_addr_in) == 8'h10 |-> reg_rdata_out[5:4] == 2'h0 &&
			reg_rdata_out[7] == $past(ch_one_overcurrent_in, 2);
	endproperty
	a_cf: assert property (p_cf) else $error("fault byte wrong");
	property p_g1;
		reg_rvalid_out && $past(reg_addr_in) == 8'h11 |-> reg_rdata_out[7:5] == 3'h0;
	endproperty
	a_g1: assert property (p_g1) else $error("global one reserved set");
	property p_g2;
		reg_rvalid_out && $past(reg_addr_in) == 8'h12 |-> reg_rdata_out[1:0] == 2'h0 &&
			reg_rdata_out[4] == $past(global_thermal_off_in, 2);
	endproperty
	a_g2: assert property (p_g2) else $error("global two wrong");
	property p_wn;
		reg_rvalid_out && $past(reg_addr_in) == 8'h13 |-> reg_rdata_out[7:5] == 3'h1;
	endproperty
	a_wn: assert property (p_wn) else $error("warning top bits wrong");
	// Exactly one answer per strobe, data holds between answers
	property p_rv;
		reg_rvalid_out == $past(reg_rd_in);
	endproperty
	a_rv: assert property (p_rv) else $error("read valid timing wrong");
	property p_hold;
		!reg_rvalid_out |-> $stable(reg_rdata_out);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule : adfs_status_bank_chk

/* bench/adfs_pin_wire.sv */
/* Pulled-up open-drain fault and warn wires.
   Assumes pin enables from the status bank, high while pulling low. */
`timescale 1ns/1ps

module adfs_pin_wire (
	input wire logic fault_oe_in, // Fault pin enable
	input wire logic warn_oe_in, // Warn pin enable
	output logic fault_wire_out, // Fault wire level
	output logic warn_wire_out // Warn wire level
);
	// wire pulled low
	// Released wire rises to the pull-up, never holds a stale low
	assign fault_wire_out = ~fault_oe_in;
	assign warn_wire_out = ~warn_oe_in;
endmodule : adfs_pin_wire

/* bench/adfs_status_bank_bench.sv */
/* Self-checking bench of the status bank over its register port.
   Assumes adfs_pin_wire as the pulled-up pin wires. */
`timescale 1ns/1ps

module adfs_status_bank_bench;
	import adfs_pkg::*;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, dg = 8'h00, rdata;
	logic wr = 1'b0, rd = 1'b0, clip = 1'b0, ilim = 1'b0, rvalid;
	logic [1:0] lo = 2'h0, s1 = 2'h1, s2 = 2'h1;
	logic [3:0] cf = 4'h0, v;
	logic [4:0] g1 = 5'h0;
	logic [2:0] g2 = 3'h0, wn = 3'h0;
	logic fpo, fpoe, wpo, wpoe, fw, ww;
	logic [7:0] ofs [9] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
	logic [7:0] rst [9] = '{8'h00, 8'h00, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
	int fails = 0, n_checks = 0;
	// Free-running 100 MHz clock
	always #5 clk_in = ~clk_in;
	adfs_status_bank adfs_status_bank_inst (.clk_in, .reset_in, .reg_addr_in(addr),
		.reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .ch_one_short_ground_in(dg[7]), .ch_one_short_power_in(dg[6]),
		.ch_one_open_load_in(dg[5]), .ch_one_shorted_load_in(dg[4]),
		.ch_two_short_ground_in(dg[3]), .ch_two_short_power_in(dg[2]),
		.ch_two_open_load_in(dg[1]), .ch_two_shorted_load_in(dg[0]),
		.ch_one_line_out_found_in(lo[1]), .ch_two_line_out_found_in(lo[0]),
		.ch_one_state_code_in(s1), .ch_two_state_code_in(s2),
		.ch_one_overcurrent_in(cf[3]), .ch_two_overcurrent_in(cf[2]),
		.ch_one_dc_fault_in(cf[1]), .ch_two_dc_fault_in(cf[0]), .invalid_clock_in(g1[4]),
		.stage_supply_over_in(g1[3]), .battery_over_in(g1[2]),
		.stage_supply_under_in(g1[1]), .battery_under_in(g1[0]),
		.global_thermal_off_in(g2[2]), .ch_one_thermal_off_in(g2[1]),
		.ch_two_thermal_off_in(g2[0]), .global_thermal_warn_in(wn[2]),
		.ch_one_thermal_warn_in(wn[1]), .ch_two_thermal_warn_in(wn[0]), .clip_in(clip),
		.ilimit_in(ilim), .fault_pin_in(fw), .fault_pin_out(fpo), .fault_pin_oe_out(fpoe),
		.warn_pin_in(ww), .warn_pin_out(wpo), .warn_pin_oe_out(wpoe));
	adfs_pin_wire adfs_pin_wire_inst (.fault_oe_in(fpoe), .warn_oe_in(wpoe),
		.fault_wire_out(fw), .warn_wire_out(ww));
	// ****************
	// Port tasks
	// ****************
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle strobe; answer looked at in its only valid cycle
	task rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 chk({7'h0, rvalid}, 8'h01);
		chk(rdata, exp);
	endtask : rd_reg
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wr_reg
	// Pin levels settle two edges after a status-byte cause, one edge after ilimit, clip or a thermal warning
	task pin_chk(input logic [7:0] exp);
		repeat (3) @(posedge clk_in);
		#1 chk({2'h0, fpo, wpo, fpoe, fw, wpoe, ww}, exp);
	endtask : pin_chk
	task setk(input int k, input logic b);
		case (k)
			0: cf[3] <= b;
			1: g2[2] <= b;
			2: g1[1] <= b;
			3: g1[3] <= b;
			4: cf[1] <= b;
			5: ilim <= b;
			6: clip <= b;
			default: wn[2] <= b;
		endcase
	endtask : setk
	task test_done;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// Cuts a hang short well past the expected run
	initial begin
		repeat (5000) @(posedge clk_in);
		fails++;
		test_done;
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		for (int i = 0; i < 9; i++) rd_reg(ofs[i], rst[i]);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_in);
			dg <= 8'h01 << i;
			rd_reg(8'h0c, 8'h01 << i);
		end
		for (int i = 1; i < 4; i++) begin
			@(posedge clk_in);
			lo <= i[1:0];
			rd_reg(8'h0e, {4'h0, i[1:0], 2'h0});
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			s1 <= i[1:0];
			s2 <= ~i[1:0];
			rd_reg(8'h0f, {i[1:0], ~i[1:0], 4'h5});
			@(posedge clk_in);
			v = 4'h1 << i;
			cf <= v;
			rd_reg(8'h10, {v[3:2], 2'h0, v[1:0], 2'h0});
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_in);
			g1 <= 5'h01 << i;
			rd_reg(8'h11, {3'h0, 5'h01 << i});
		end
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_in);
			g2 <= 3'h1 << i;
			wn <= 3'h1 << i;
			rd_reg(8'h12, {3'h0, 3'h1 << i, 2'h0});
			rd_reg(8'h13, {3'h1, 3'h1 << i, 2'h0});
		end
		@(posedge clk_in);
		{dg, lo, cf, g1, g2, wn} <= '0;
		// Writes to status bytes leave them alone, reads repeat
		wr_reg(8'h10, 8'hff);
		wr_reg(8'h13, 8'h00);
		rd_reg(8'h10, 8'h00);
		rd_reg(8'h13, 8'h20);
		rd_reg(8'h13, 8'h20);
		// Each pin category raised, then masked
		for (int k = 0; k < 8; k++) begin
			@(posedge clk_in);
			setk(k, 1'b1);
			pin_chk(k < 6 ? 8'h09 : 8'h06);
			wr_reg(8'h14, 8'h80 >> k);
			rd_reg(8'h14, 8'h80 >> k);
			pin_chk(8'h05);
			@(posedge clk_in);
			setk(k, 1'b0);
			wr_reg(8'h14, 8'h00);
		end
		// Clock fault has no pin category, so both wires stay released
		@(posedge clk_in);
		g1 <= 5'h10;
		pin_chk(8'h05);
		@(posedge clk_in);
		g1 <= 5'h00;
		// Second reset in mid-run restores mask and power-on flag
		wr_reg(8'h14, 8'hff);
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_reg(8'h14, 8'h00);
		rd_reg(8'h13, 8'h20);
		test_done;
	end
endmodule : adfs_status_bank_bench

bind adfs_status_bank adfs_status_bank_chk adfs_status_bank_chk_inst (.clk_in, .reset_in,
	.reg_addr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .ch_one_short_ground_in,
	.ch_two_shorted_load_in, .ch_one_line_out_found_in, .ch_one_overcurrent_in,
	.global_thermal_off_in);
